// ==== shared/msse_pkg.sv ====
// Package: constants and opcodes for the subtract/swap/skip/xor/table execution unit
//
// Summary of operation
// - Subtract carry is one unless operand exceeds accumulator (borrow)
// - Subtract memory from accumulator into accumulator
// - Subtract result written back to memory byte
// - Subtract immediate from accumulator into accumulator
// - Swap memory byte nibbles in place, no flags
// - Swapped memory byte loaded into accumulator only
// - Skip next instruction when memory byte zero
// - Copy byte to accumulator, skip if zero
// - Skip next instruction when selected bit zero
// - Taken skip inserts one dummy cycle
// - Table read uses high and low pointers
// - Last page table read uses low pointer
// - Xor memory into accumulator, zero flag only
// - Xor result written to memory byte
// - Xor immediate into accumulator, zero flag only
package msse_pkg;

  localparam int DATA_W  = 8;
  localparam int DADDR_W = 8;
  localparam int PADDR_W = 12;
  localparam int PWORD_W = 16;
  localparam int OP_W    = 4;

  // Register offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_ACC   = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TLOW  = 8'h08;
  localparam logic [7:0] OFS_THIGH = 8'h0C;
  localparam logic [7:0] OFS_LATCH = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Flag register field positions
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;

  // Number of idle slots added by a taken skip
  localparam logic [1:0] SKIP_DUMMY_CYCLES = 2'h1;

  typedef enum logic [OP_W-1:0] {
    MSSE_OP_SUB_ACC   = 4'b0000,
    MSSE_OP_SUB_MEM   = 4'b0001,
    MSSE_OP_SUB_IMM   = 4'b0010,
    MSSE_OP_SWAP_MEM  = 4'b0011,
    MSSE_OP_SWAP_ACC  = 4'b0100,
    MSSE_OP_SKZ       = 4'b0101,
    MSSE_OP_SKZ_MOVE  = 4'b0110,
    MSSE_OP_SKZ_BIT   = 4'b0111,
    MSSE_OP_TRD_CUR   = 4'b1000,
    MSSE_OP_TRD_LAST  = 4'b1001,
    MSSE_OP_XOR_ACC   = 4'b1010,
    MSSE_OP_XOR_MEM   = 4'b1011,
    MSSE_OP_XOR_IMM   = 4'b1100
  } msse_op_e;

  typedef enum logic [1:0] {
    MSSE_ST_IDLE  = 2'b00,
    MSSE_ST_TREAD = 2'b01,
    MSSE_ST_DUMMY = 2'b10
  } msse_state_e;

endpackage

// ==== verif/msse_exec_bench.sv ====
// Testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module msse_exec_bench;
  import msse_pkg::*;
  logic        aclk, aresetn, issue_valid, issue_ready, skip_taken, dummy_cycle, dmem_we, pmem_re;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  msse_op_e    issue_op;
  logic [7:0]  issue_addr, issue_imm, dmem_raddr, dmem_rdata, dmem_waddr, dmem_wdata, s_awaddr, s_araddr, lat;
  logic [2:0]  issue_bit;
  logic [11:0] pmem_addr;
  logic [15:0] pmem_rdata;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  mem [256];
  logic [7:0]  pa [5] = '{8'h50, 8'h30, 8'h80, 8'h22, 8'h05};
  logic [7:0]  pm [5] = '{8'h30, 8'h58, 8'h01, 8'h22, 8'h00};
  int          n_errors, compares, cyc;

  msse_exec #(.HAS_HIGH_PTR(1)) i_msse_exec (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_op(issue_op), .issue_addr(issue_addr), .issue_imm(issue_imm), .issue_bit(issue_bit),
    .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .dmem_raddr(dmem_raddr), .dmem_rdata(dmem_rdata),
    .dmem_we(dmem_we), .dmem_waddr(dmem_waddr), .dmem_wdata(dmem_wdata), .pmem_re(pmem_re),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));

  ////////////////////////////////////////////////////////////////
  // Memories seen by the unit
  assign dmem_rdata = mem[dmem_raddr];
  assign pmem_rdata = pmem_re ? {4'h5, pmem_addr} : 16'h0000;
  always @(posedge aclk) begin
    if (dmem_we) mem[dmem_waddr] <= dmem_wdata;
  end

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Tasks
  task test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function logic [3:0] sf(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] r;
    r = a - m;
    return {(a[7] != m[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= m[3:0], a >= m};
  endfunction

  task axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b, ta, tw, tb;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w || b) begin
      @(negedge aclk);
      ta = aw & s_awready;
      tw = w & s_wready;
      tb = s_bvalid;
      if (tb) chk({30'h0, s_bresp}, 32'h0);
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (tb) s_bready <= 1'b0;
      aw = aw & ~ta;
      w = w & ~tw;
      b = ~tb;
    end
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d);
    logic ta, done;
    done = 1'b0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = s_arvalid & s_arready;
      done = s_rvalid;
      d = s_rdata;
      if (done) chk({30'h0, s_rresp}, 32'h0);
      @(posedge aclk);
      if (ta) s_arvalid <= 1'b0;
      if (done) s_rready <= 1'b0;
    end
  endtask

  task run(input msse_op_e op, input logic [7:0] a, input logic [7:0] m, input logic [3:0] fi);
    logic [7:0] ea, em, r;
    logic [3:0] ef;
    logic       es, sk, dm, ok;
    axw(OFS_ACC, {24'h0, a});
    axw(OFS_FLAGS, {28'h0, fi});
    mem[8'h05] = (op == MSSE_OP_SUB_IMM || op == MSSE_OP_XOR_IMM) ? ~m : m;
    ea = a;
    ef = fi;
    em = mem[8'h05];
    es = 1'b0;
    r = a - m;
    case (op)
      MSSE_OP_SUB_ACC, MSSE_OP_SUB_IMM: {ea, ef} = {r, sf(a, m)};
      MSSE_OP_SUB_MEM:  {em, ef} = {r, sf(a, m)};
      MSSE_OP_SWAP_MEM: em = {m[3:0], m[7:4]};
      MSSE_OP_SWAP_ACC: ea = {m[3:0], m[7:4]};
      MSSE_OP_SKZ:      es = (m == 8'h00);
      MSSE_OP_SKZ_MOVE: {ea, es} = {m, m == 8'h00};
      MSSE_OP_SKZ_BIT:  es = ~m[3];
      MSSE_OP_XOR_ACC, MSSE_OP_XOR_IMM: {ea, ef[2]} = {a ^ m, (a ^ m) == 8'h00};
      MSSE_OP_XOR_MEM:  {em, ef[2]} = {a ^ m, (a ^ m) == 8'h00};
      MSSE_OP_TRD_CUR:  {em, lat} = {8'h34, 8'h52};
      default:          {em, lat} = {8'h34, 8'h5F};
    endcase
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_imm <= m;
    do begin
      @(negedge aclk);
      ok = issue_ready;
      @(posedge aclk);
    end while (!ok);
    issue_valid <= 1'b0;
    @(negedge aclk);
    sk = skip_taken;
    @(negedge aclk);
    dm = dummy_cycle;
    axr(OFS_ACC, rd);
    chk(rd, {24'h0, ea});
    axr(OFS_FLAGS, rd);
    chk(rd, {28'h0, ef});
    axr(OFS_LATCH, rd);
    chk(rd, {24'h0, lat});
    axr(OFS_STAT, rd);
    chk(rd, {29'h0, es, MSSE_ST_IDLE});
    chk({31'h0, sk}, {31'h0, es});
    chk({31'h0, dm}, {31'h0, es});
    chk({24'h0, mem[8'h05]}, {24'h0, em});
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, issue_valid, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {issue_imm, s_awaddr, s_araddr, s_wdata, lat} = '0;
    issue_op = MSSE_OP_SUB_ACC;
    issue_addr = 8'h05;
    issue_bit = 3'h3;
    s_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_ACC, rd);
    chk(rd, 32'h0);
    axr(8'h18, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      for (int o = 0; o < 13; o++) begin
        if (o != 8 && o != 9) run(msse_op_e'(4'(o)), pa[i], pm[i], (i % 2) ? 4'h5 : 4'hA);
      end
    end
    axw(OFS_TLOW, 32'h34);
    axw(OFS_THIGH, 32'h2);
    axr(OFS_THIGH, rd);
    chk(rd, 32'h2);
    run(MSSE_OP_TRD_CUR, 8'h11, 8'h00, 4'h6);
    run(MSSE_OP_TRD_LAST, 8'h11, 8'h00, 4'h9);
    test_done();
  end
endmodule
`default_nettype wire

// ==== verilog/msse_alu.sv ====
// Arithmetic and logic for subtract, swap and exclusive-or
`timescale 1ns/1ps
`default_nettype none
module msse_alu (
  input  wire logic [msse_pkg::DATA_W-1:0] acc_val,
  input  wire logic [msse_pkg::DATA_W-1:0] opnd,
  output logic      [msse_pkg::DATA_W-1:0] diff,
  output logic      [msse_pkg::DATA_W-1:0] xres,
  output logic      [msse_pkg::DATA_W-1:0] swapped,
  output logic                             c_out,
  output logic                             ac_out,
  output logic                             ov_out,
  output logic                             z_diff,
  output logic                             z_xor
);
  import msse_pkg::*;

  wire logic [DATA_W:0] wide_diff;
  wire logic [4:0]      nib_diff;

  assign wide_diff = {1'b0, acc_val} - {1'b0, opnd};
  assign nib_diff  = {1'b0, acc_val[3:0]} - {1'b0, opnd[3:0]};
  assign diff      = wide_diff[DATA_W-1:0];
  assign c_out     = ~wide_diff[DATA_W];
  assign ac_out    = ~nib_diff[4];
  assign ov_out    = (acc_val[7] ^ opnd[7]) & (acc_val[7] ^ diff[7]);
  assign z_diff    = (diff == 8'h00);
  assign xres      = acc_val ^ opnd;
  assign z_xor     = (xres == 8'h00);
  assign swapped   = {opnd[3:0], opnd[7:4]};
endmodule
`default_nettype wire

// ==== verilog/msse_exec.sv ====
// Execution unit with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module msse_exec #(
  parameter int HAS_HIGH_PTR = 1
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          clk_en,
  // Instruction issue
  input  wire logic                          issue_valid,
  output logic                               issue_ready,
  input  wire msse_pkg::msse_op_e            issue_op,
  input  wire logic [msse_pkg::DADDR_W-1:0]  issue_addr,
  input  wire logic [msse_pkg::DATA_W-1:0]   issue_imm,
  input  wire logic [2:0]                    issue_bit,
  output logic                               skip_taken,
  output logic                               dummy_cycle,
  // Data memory
  output logic      [msse_pkg::DADDR_W-1:0]  dmem_raddr,
  input  wire logic [msse_pkg::DATA_W-1:0]   dmem_rdata,
  output logic                               dmem_we,
  output logic      [msse_pkg::DADDR_W-1:0]  dmem_waddr,
  output logic      [msse_pkg::DATA_W-1:0]   dmem_wdata,
  // Program memory
  output logic                               pmem_re,
  output logic      [msse_pkg::PADDR_W-1:0]  pmem_addr,
  input  wire logic [msse_pkg::PWORD_W-1:0]  pmem_rdata,
  // AXI4-Lite
  input  wire logic [7:0]                    s_awaddr,
  input  wire logic                          s_awvalid,
  output logic                               s_awready,
  input  wire logic [31:0]                   s_wdata,
  input  wire logic [3:0]                    s_wstrb,
  input  wire logic                          s_wvalid,
  output logic                               s_wready,
  output logic      [1:0]                    s_bresp,
  output logic                               s_bvalid,
  input  wire logic                          s_bready,
  input  wire logic [7:0]                    s_araddr,
  input  wire logic                          s_arvalid,
  output logic                               s_arready,
  output logic      [31:0]                   s_rdata,
  output logic      [1:0]                    s_rresp,
  output logic                               s_rvalid,
  input  wire logic                          s_rready
);
  import msse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [DATA_W-1:0]  accumulator_reg_q;
  logic [3:0]         flags_q;
  logic [DATA_W-1:0]  table_low_pointer_q;
  logic [DATA_W-1:0]  table_high_pointer_q;
  logic [DATA_W-1:0]  table_high_latch_q;
  msse_state_e        state_q;
  logic [DADDR_W-1:0] tdst_q;
  logic [DATA_W-1:0]  skip_count_q;
  logic [DATA_W-1:0]  exec_count_q;
  logic               skip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic [DATA_W-1:0] diff, xres, swapped, alu_opnd;
  wire logic c_out, ac_out, ov_out, z_diff, z_xor;
  wire logic fire, is_sub, is_xor, mem_zero, bit_zero, do_skip;
  wire logic acc_we, sub_mem_op, xor_mem_op;
  wire logic [DATA_W-1:0] acc_d;
  wire logic [3:0] flags_d;

  assign issue_ready = clk_en & (state_q == MSSE_ST_IDLE);
  assign fire        = issue_valid & issue_ready;
  assign dmem_raddr  = issue_addr;
  assign is_sub      = (issue_op == MSSE_OP_SUB_ACC) | (issue_op == MSSE_OP_SUB_MEM) |
                       (issue_op == MSSE_OP_SUB_IMM);
  assign is_xor      = (issue_op == MSSE_OP_XOR_ACC) | (issue_op == MSSE_OP_XOR_MEM) |
                       (issue_op == MSSE_OP_XOR_IMM);
  assign sub_mem_op  = (issue_op == MSSE_OP_SUB_MEM);
  assign xor_mem_op  = (issue_op == MSSE_OP_XOR_MEM);
  assign alu_opnd    = ((issue_op == MSSE_OP_SUB_IMM) | (issue_op == MSSE_OP_XOR_IMM)) ?
                       issue_imm : dmem_rdata;
  assign mem_zero    = (dmem_rdata == 8'h00);
  assign bit_zero    = ~dmem_rdata[issue_bit];
  assign do_skip     = ((issue_op == MSSE_OP_SKZ) & mem_zero) |
                       ((issue_op == MSSE_OP_SKZ_MOVE) & mem_zero) |
                       ((issue_op == MSSE_OP_SKZ_BIT) & bit_zero);
  assign acc_we      = (issue_op == MSSE_OP_SUB_ACC) | (issue_op == MSSE_OP_SUB_IMM) |
                       (issue_op == MSSE_OP_XOR_ACC) | (issue_op == MSSE_OP_XOR_IMM) |
                       (issue_op == MSSE_OP_SWAP_ACC) | (issue_op == MSSE_OP_SKZ_MOVE);
  assign acc_d       = is_sub ? diff :
                       is_xor ? xres :
                       (issue_op == MSSE_OP_SWAP_ACC) ? swapped :
                       dmem_rdata;
  assign flags_d     = is_sub ? {ov_out, z_diff, ac_out, c_out} :
                       is_xor ? {flags_q[FLG_OV], z_xor, flags_q[FLG_AC], flags_q[FLG_C]} :
                       flags_q;

  msse_alu u_alu (
    .acc_val (accumulator_reg_q),
    .opnd    (alu_opnd),
    .diff    (diff),
    .xres    (xres),
    .swapped (swapped),
    .c_out   (c_out),
    .ac_out  (ac_out),
    .ov_out  (ov_out),
    .z_diff  (z_diff),
    .z_xor   (z_xor)
  );

  // Table address: last page forces the upper bits high
  wire logic [PADDR_W-1:0] cur_page_addr, last_page_addr;
  wire logic [PADDR_W-DATA_W-1:0] hi_part;
  assign hi_part        = (HAS_HIGH_PTR != 0) ? table_high_pointer_q[PADDR_W-DATA_W-1:0] :
                          {(PADDR_W-DATA_W){1'b0}};
  assign cur_page_addr  = {hi_part, table_low_pointer_q};
  assign last_page_addr = {{(PADDR_W-DATA_W){1'b1}}, table_low_pointer_q};

  ////////////////////////////////////////////////////////////////////////////
  // Instruction sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= MSSE_ST_IDLE;
      tdst_q      <= RST_BYTE;
      skip_taken  <= 1'b0;
      dummy_cycle <= 1'b0;
      pmem_re     <= 1'b0;
      pmem_addr   <= '0;
      dmem_we     <= 1'b0;
      dmem_waddr  <= RST_BYTE;
      dmem_wdata  <= RST_BYTE;
    end else if (clk_en) begin
      skip_taken  <= 1'b0;
      dummy_cycle <= 1'b0;
      pmem_re     <= 1'b0;
      dmem_we     <= 1'b0;
      case (state_q)
        MSSE_ST_IDLE: begin
          if (fire) begin
            dmem_waddr <= issue_addr;
            if (do_skip) begin
              skip_taken <= 1'b1;
              state_q    <= MSSE_ST_DUMMY;
            end
            if (sub_mem_op) begin
              dmem_we    <= 1'b1;
              dmem_wdata <= diff;
            end
            if (xor_mem_op) begin
              dmem_we    <= 1'b1;
              dmem_wdata <= xres;
            end
            if (issue_op == MSSE_OP_SWAP_MEM) begin
              dmem_we    <= 1'b1;
              dmem_wdata <= swapped;
            end
            if ((issue_op == MSSE_OP_TRD_CUR) | (issue_op == MSSE_OP_TRD_LAST)) begin
              pmem_re   <= 1'b1;
              pmem_addr <= (issue_op == MSSE_OP_TRD_LAST) ? last_page_addr : cur_page_addr;
              tdst_q    <= issue_addr;
              state_q   <= MSSE_ST_TREAD;
            end
          end
        end
        MSSE_ST_TREAD: begin
          dmem_we    <= 1'b1;
          dmem_waddr <= tdst_q;
          dmem_wdata <= pmem_rdata[DATA_W-1:0];
          state_q    <= MSSE_ST_IDLE;
        end
        MSSE_ST_DUMMY: begin
          dummy_cycle <= 1'b1;
          state_q     <= MSSE_ST_IDLE;
        end
        default: state_q <= MSSE_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic               aw_held_q, w_held_q;
  logic [7:0]         aw_addr_q;
  logic [31:0]        w_data_q;
  logic               w_lane0_q;
  wire logic          wr_go, sw_wr_acc, sw_wr_tl, sw_wr_th, sw_wr_fl;
  assign s_awready = ~aw_held_q & ~s_bvalid;
  assign s_wready  = ~w_held_q & ~s_bvalid;
  assign wr_go     = aw_held_q & w_held_q & ~s_bvalid & clk_en & (state_q == MSSE_ST_IDLE) & ~fire;
  assign sw_wr_acc = wr_go & w_lane0_q & (aw_addr_q == OFS_ACC);
  assign sw_wr_fl  = wr_go & w_lane0_q & (aw_addr_q == OFS_FLAGS);
  assign sw_wr_tl  = wr_go & w_lane0_q & (aw_addr_q == OFS_TLOW);
  assign sw_wr_th  = wr_go & w_lane0_q & (aw_addr_q == OFS_THIGH);
  assign s_bresp   = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_lane0_q <= 1'b0;
      s_bvalid  <= 1'b0;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      if (s_wvalid & s_wready) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_wdata;
        w_lane0_q <= s_wstrb[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        s_bvalid  <= 1'b1;
      end else if (s_bvalid & s_bready) begin
        s_bvalid  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accumulator_reg_q    <= RST_BYTE;
      flags_q              <= RST_FLAGS;
      table_low_pointer_q  <= RST_BYTE;
      table_high_pointer_q <= RST_BYTE;
      table_high_latch_q   <= RST_BYTE;
      skip_q               <= 1'b0;
    end else if (clk_en) begin
      if (fire & acc_we) begin
        accumulator_reg_q <= acc_d;
      end else if (sw_wr_acc) begin
        accumulator_reg_q <= w_data_q[DATA_W-1:0];
      end
      if (fire) begin
        flags_q <= flags_d;
        skip_q  <= do_skip;
      end else if (sw_wr_fl) begin
        flags_q <= w_data_q[3:0];
      end
      if (sw_wr_tl) begin
        table_low_pointer_q <= w_data_q[DATA_W-1:0];
      end
      if (sw_wr_th) begin
        table_high_pointer_q <= w_data_q[DATA_W-1:0];
      end
      if (state_q == MSSE_ST_TREAD) begin
        table_high_latch_q <= pmem_rdata[PWORD_W-1:DATA_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  wire logic [31:0] rd_mux;
  assign s_arready = ~s_rvalid;
  assign s_rresp   = 2'h0;
  assign rd_mux    = (s_araddr == OFS_ACC)   ? {24'h0, accumulator_reg_q} :
                     (s_araddr == OFS_FLAGS) ? {28'h0, flags_q} :
                     (s_araddr == OFS_TLOW)  ? {24'h0, table_low_pointer_q} :
                     (s_araddr == OFS_THIGH) ? {24'h0, table_high_pointer_q} :
                     (s_araddr == OFS_LATCH) ? {24'h0, table_high_latch_q} :
                     (s_araddr == OFS_STAT)  ? {29'h0, skip_q, state_q} :
                     32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0;
    end else if (s_arvalid & s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_mux;
    end else if (s_rvalid & s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_count_q <= 8'h00;
      exec_count_q <= 8'h00;
    end else begin
      if (skip_taken & clk_en) skip_count_q <= skip_count_q + 8'h01;
      if (fire) exec_count_q <= exec_count_q + 8'h01;
    end
  end

  AST_SUB_CARRY: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & is_sub |=> flags_q[FLG_C] == ($past(accumulator_reg_q) >= $past(alu_opnd)))
    else $error("carry wrong after subtract");
  AST_SUB_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SUB_ACC) |=>
      accumulator_reg_q == 8'($past(accumulator_reg_q) - $past(dmem_rdata)))
    else $error("accumulator subtract wrong");
  AST_SUB_MEM: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & sub_mem_op |=> dmem_we && dmem_wdata == 8'($past(accumulator_reg_q) - $past(dmem_rdata))
      && accumulator_reg_q == $past(accumulator_reg_q))
    else $error("memory subtract wrong");
  AST_SUB_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SUB_IMM) |=>
      accumulator_reg_q == 8'($past(accumulator_reg_q) - $past(issue_imm)))
    else $error("immediate subtract wrong");
  AST_SWAP_MEM: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SWAP_MEM) |=> dmem_we && dmem_wdata[3:0] == $past(dmem_rdata[7:4])
      && flags_q == $past(flags_q))
    else $error("memory swap wrong");
  AST_SWAP_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SWAP_ACC) |=> !dmem_we && accumulator_reg_q[7:4] == $past(dmem_rdata[3:0]))
    else $error("accumulator swap wrong");
  AST_SKZ: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SKZ) |=> skip_taken == ($past(dmem_rdata) == 8'h00))
    else $error("zero skip wrong");
  AST_SKZ_MOVE: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SKZ_MOVE) |=> accumulator_reg_q == $past(dmem_rdata)
      && flags_q == $past(flags_q))
    else $error("move skip wrong");
  AST_SKZ_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SKZ_BIT) & dmem_rdata[issue_bit] |=> !skip_taken)
    else $error("bit skip taken on one");
  AST_DUMMY: assert property (@(posedge aclk) disable iff (!aresetn)
    skip_taken & clk_en |-> !issue_ready ##1 dummy_cycle)
    else $error("no dummy cycle after skip");
  AST_TRD_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == MSSE_ST_TREAD) & clk_en |=> table_high_latch_q == $past(pmem_rdata[15:8])
      && dmem_wdata == $past(pmem_rdata[7:0]))
    else $error("table read split wrong");
  AST_TRD_LAST: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_TRD_LAST) |=> pmem_re && pmem_addr[11:8] == 4'hF)
    else $error("last page address wrong");
  AST_XOR_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_XOR_ACC) |=> accumulator_reg_q == ($past(accumulator_reg_q) ^ $past(dmem_rdata))
      && flags_q[FLG_C] == $past(flags_q[FLG_C]))
    else $error("accumulator xor wrong");
  AST_XOR_MEM: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & xor_mem_op |=> dmem_wdata == ($past(accumulator_reg_q) ^ $past(dmem_rdata))
      && flags_q[FLG_Z] == (dmem_wdata == 8'h00))
    else $error("memory xor wrong");
  AST_XOR_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_XOR_IMM) |=> flags_q[FLG_OV] == $past(flags_q[FLG_OV]))
    else $error("immediate xor touched overflow");
  AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    fire & (issue_op == MSSE_OP_SUB_ACC) |=> flags_q[FLG_Z] == (accumulator_reg_q == 8'h00))
    else $error("zero flag wrong");

  COV_SKIP: cover property (@(posedge aclk) skip_taken ##1 dummy_cycle);
  COV_TREAD: cover property (@(posedge aclk) pmem_re ##1 dmem_we);
  COV_BORROW: cover property (@(posedge aclk) fire & is_sub & !c_out);
  COV_AXI: cover property (@(posedge aclk) s_bvalid & s_bready);
  COV_COUNT: cover property (@(posedge aclk) skip_count_q == 8'h04 && exec_count_q > skip_count_q);
endmodule
`default_nettype wire
